// *** asr_rx.sv ***
// Asynchronous serial receiver core with parity, timeout and flow control
`timescale 1ns/1ps
module asr_rx
    import asr_pkg::*;
(
    input wire logic CLK_IN,             // System clock, 250 MHz
    input wire logic RST_N_IN,           // Async reset, low
    input wire logic RXD_IN,             // Serial receive pin
    input wire logic START_IN,           // Pulse: begin one reception
    input wire logic [15:0] FORMAT_IN,   // Line format word
    input wire logic [3:0] WIDTH_IN,     // Frame data width, 0 = unset
    input wire logic [15:0] TIMEOUT_IN,  // Timeout in ms
    input wire logic TIMEOUT_EN_IN,      // Timeout enabled
    output logic BUSY_OUT,               // Reception in progress
    output logic FLOW_OUT,               // Flow control pin
    output logic DONE_OUT,               // Pulse: frame received
    output logic PERR_OUT,               // Pulse: parity abort
    output logic TOUT_OUT,               // Pulse: timeout abort
    output logic [7:0] DATA_OUT          // Received data
);
    asr_state_t state_ff;
    asr_cfg_t cfg_ff;
    asr_result_t res_ff;
    logic rx_sync;
    logic rx_lvl;
    logic rx_prev_ff;
    logic [23:0] bit_cnt_ff;
    logic [23:0] period_cyc;
    logic [3:0] idx_ff;
    logic [3:0] nbits;
    logic par_mode;
    logic [8:0] shift_ff;
    logic [17:0] ms_div_ff;
    logic [15:0] ms_cnt_ff;
    logic bit_tick;
    logic half_tick;

    asr_sync u_sync (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .d_in(RXD_IN),
        .q_out(rx_sync)
    );

    // ************************************************************
    // Frame format decode
    // ************************************************************
    function automatic logic [3:0] eff_width(input logic [3:0] w, input logic par);
        logic [3:0] r;
        r = w;
        if (w == 4'h0)
            r = WIDTH_DEFAULT;
        else if (w < WIDTH_MIN)
            r = WIDTH_MIN;
        else if (w > WIDTH_NINE)
            r = WIDTH_NINE;
        if (par && w == 4'h0)
            r = WIDTH_DEFAULT;
        if (!par && r == WIDTH_NINE)
            r = WIDTH_NINE;
        return r;
    endfunction

    assign par_mode = cfg_ff.line_format[FMT_PARITY_BIT] || (cfg_ff.data_width == WIDTH_NINE);
    // Total bits after start: data plus parity; width nine forces parity, eight data bits plus parity
    assign nbits = eff_width(cfg_ff.data_width, par_mode);
    assign rx_lvl = rx_sync ^ cfg_ff.line_format[FMT_INVERT_BIT];
    // Period in us times cycles per us
    assign period_cyc = 24'((cfg_ff.line_format[FMT_PERIOD_W-1:0] + PERIOD_OFFSET_US)
        * CYC_PER_US);
    assign bit_tick = (bit_cnt_ff == period_cyc - 24'h0000_01);
    assign half_tick = (bit_cnt_ff == (period_cyc >> 1));

    // ************************************************************
    // Control sequence
    // ************************************************************
    always_ff @(posedge CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            state_ff <= ST_IDLE;
            cfg_ff <= '0;
            res_ff <= '0;
            bit_cnt_ff <= '0;
            idx_ff <= '0;
            shift_ff <= '0;
            rx_prev_ff <= 1'b1;
        end
        else
        begin
            res_ff.done <= 1'b0;
            res_ff.parity_err <= 1'b0;
            res_ff.timeout <= 1'b0;
            rx_prev_ff <= rx_lvl;
            case (state_ff)
                ST_IDLE:
                begin
                    if (START_IN)
                    begin
                        cfg_ff <= '{FORMAT_IN, WIDTH_IN, TIMEOUT_IN, TIMEOUT_EN_IN};
                        state_ff <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    bit_cnt_ff <= '0;
                    if (cfg_ff.timeout_en && ms_cnt_ff == cfg_ff.timeout_ms)
                    begin
                        res_ff.timeout <= 1'b1;
                        state_ff <= ST_IDLE;
                    end
                    else if (rx_prev_ff && !rx_lvl)
                        state_ff <= ST_START;
                end
                ST_START:
                begin
                    bit_cnt_ff <= bit_cnt_ff + 24'h0000_01;
                    if (half_tick)
                    begin
                        bit_cnt_ff <= '0;
                        idx_ff <= '0;
                        // Stale upper bits of a wider earlier frame must not leak
                        shift_ff <= '0;
                        // Glitch shorter than half a bit is not a start
                        state_ff <= rx_lvl ? ST_WAIT : ST_BITS;
                    end
                end
                ST_BITS:
                begin
                    bit_cnt_ff <= bit_cnt_ff + 24'h0000_01;
                    if (bit_tick)
                    begin
                        bit_cnt_ff <= '0;
                        shift_ff[idx_ff] <= rx_lvl;
                        idx_ff <= idx_ff + 4'h1;
                        if (idx_ff == nbits - 4'h1)
                            state_ff <= ST_STOP;
                    end
                end
                ST_STOP:
                begin
                    bit_cnt_ff <= bit_cnt_ff + 24'h0000_01;
                    if (bit_tick)
                    begin
                        // Even count of ones over data and parity
                        if (par_mode && ^(shift_ff & ((9'h001 << nbits) - 9'h001)))
                            res_ff.parity_err <= 1'b1;
                        else
                        begin
                            res_ff.done <= 1'b1;
                            res_ff.data <= par_mode
                                ? 8'(shift_ff & ((9'h001 << (nbits - 4'h1)) - 9'h001))
                                : 8'(shift_ff);
                        end
                        state_ff <= ST_IDLE;
                    end
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Millisecond timeout counter
    // ************************************************************
    always_ff @(posedge CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            ms_div_ff <= '0;
            ms_cnt_ff <= RST_TIMEOUT;
        end
        else if (state_ff != ST_WAIT)
        begin
            ms_div_ff <= '0;
            ms_cnt_ff <= RST_TIMEOUT;
        end
        else if (ms_div_ff == 18'(CYC_PER_MS - 1))
        begin
            ms_div_ff <= '0;
            ms_cnt_ff <= ms_cnt_ff + 16'h0001;
        end
        else
            ms_div_ff <= ms_div_ff + 18'h0_0001;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign BUSY_OUT = (state_ff != ST_IDLE);
    // Go is low when true polarity; stop level otherwise
    assign FLOW_OUT = BUSY_OUT ? cfg_ff.line_format[FMT_INVERT_BIT]
        : ~cfg_ff.line_format[FMT_INVERT_BIT];
    assign DONE_OUT = res_ff.done;
    assign PERR_OUT = res_ff.parity_err;
    assign TOUT_OUT = res_ff.timeout;
    assign DATA_OUT = res_ff.data;

    // ************************************************************
    // Checks
    // ************************************************************
    a_outcome_onehot: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        $onehot0({DONE_OUT, PERR_OUT, TOUT_OUT}))
        else $error("more than one outcome at once");
    a_perr_ends_rx: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        PERR_OUT |-> !BUSY_OUT)
        else $error("parity abort left receiver busy");
    a_no_tout_off: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        TOUT_OUT |-> cfg_ff.timeout_en)
        else $error("timeout without enable");
    a_flow_go: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        BUSY_OUT |-> FLOW_OUT == cfg_ff.line_format[FMT_INVERT_BIT])
        else $error("flow pin not at go level");
    a_flow_taken: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        $rose(BUSY_OUT) |-> FLOW_OUT == $past(FORMAT_IN[FMT_INVERT_BIT]))
        else $error("flow go level not from taken format");
    a_seven_msb: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        DONE_OUT && cfg_ff.line_format[FMT_PARITY_BIT] && cfg_ff.data_width == 4'h0
        |-> !DATA_OUT[7])
        else $error("seven bit data has msb set");
    a_start_to_wait: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        state_ff == ST_IDLE && START_IN |=> state_ff == ST_WAIT)
        else $error("start not taken");
    a_bit_period: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        state_ff == ST_BITS |-> bit_cnt_ff < period_cyc)
        else $error("bit counter past period");
    a_par_check: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        state_ff == ST_STOP && bit_tick && !par_mode |=> !PERR_OUT)
        else $error("parity error without parity");
endmodule

// *** asr_pkg.sv ***
// Shared constants and carrier types of the asynchronous serial receiver
package asr_pkg;
    localparam int CLK_MHZ = 250;
    localparam int CLK_PERIOD_NS = 4;
    // Line format word fields
    localparam int FMT_PERIOD_LSB = 0;
    localparam int FMT_PERIOD_W = 12;
    localparam int FMT_PARITY_BIT = 13;
    localparam int FMT_INVERT_BIT = 14;
    localparam logic [11:0] PERIOD_OFFSET_US = 12'h0014;
    // Width setting
    localparam logic [3:0] WIDTH_MIN = 4'h4;
    localparam logic [3:0] WIDTH_DEFAULT = 4'h8;
    localparam logic [3:0] WIDTH_NINE = 4'h9;
    // Timeout
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int CYC_PER_US = 1000 / CLK_PERIOD_NS;
    localparam logic [15:0] RST_TIMEOUT = 16'h0000;

    typedef struct packed {
        logic [15:0] line_format;
        logic [3:0] data_width;
        logic [15:0] timeout_ms;
        logic timeout_en;
    } asr_cfg_t;

    typedef struct packed {
        logic [7:0] data;
        logic done;
        logic parity_err;
        logic timeout;
    } asr_result_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_WAIT = 5'b00010,
        ST_START = 5'b00100,
        ST_BITS = 5'b01000,
        ST_STOP = 5'b10000
    } asr_state_t;
endpackage

// *** asr_sync.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module asr_sync
    import asr_pkg::*;
(
    input wire logic clk_in,    // System clock
    input wire logic rst_n_in,  // Async reset, low
    input wire logic d_in,      // Raw pin
    output logic q_out          // Filtered level
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s1_ff <= 1'b1;
            s2_ff <= 1'b1;
            s3_ff <= 1'b1;
        end
        else
        begin
            s1_ff <= d_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Change counts only once stages two and three agree
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            q_out <= 1'b1;
        else if (s2_ff == s3_ff)
            q_out <= s3_ff;
    end
endmodule

// *** asr_tx_model.sv ***
// Behavioural remote transmitter feeding the receive pin
`timescale 1ns/1ps
module asr_tx_model (
    input wire logic clk_in,            // System clock
    input wire logic send_in,           // Pulse: send one frame
    input wire logic [7:0] data_in,     // Payload, LSB first
    input wire logic [3:0] nbits_in,    // Payload bit count
    input wire logic par_in,            // Append even parity
    input wire logic bad_par_in,        // Corrupt parity on purpose
    input wire logic inv_in,            // Inverted line levels
    input wire logic [31:0] period_in,  // Cycles per bit
    output logic txd_out                // Line to receiver
);
    logic [11:0] frame;
    int len;
    initial
    begin
        txd_out = 1'b1;
        forever
        begin
            // Idle level follows polarity so a mode change is no start edge
            while (!send_in)
            begin
                txd_out <= ~inv_in;
                @(posedge clk_in);
            end
            frame = '0;
            for (int i = 0; i < nbits_in; i++)
                frame[1 + i] = data_in[i];
            len = 1 + int'(nbits_in);
            if (par_in)
            begin
                frame[len] = (^frame) ^ bad_par_in;
                len++;
            end
            frame[len] = 1'b1;
            len++;
            for (int i = 0; i < len; i++)
            begin
                txd_out <= frame[i] ^ inv_in;
                repeat (period_in) @(posedge clk_in);
            end
        end
    end
endmodule

// *** testbench.sv ***
// Self-checking bench of the serial receiver against the transmitter model
`timescale 1ns/1ps
module testbench;
    import asr_pkg::*;
    typedef struct packed {
        logic [15:0] fmt;
        logic [3:0] w;
        logic [7:0] d;
        logic [3:0] nb;
        logic par;
    } asr_row_t;
    // Shortest bit time keeps each frame near 30k cycles
    localparam logic [31:0] PERIOD = 32'h0000_1388;
    logic clk, rst_n, start, ten, txd, send, par, bad, inv;
    logic [15:0] fmt, tmo;
    logic [3:0] w, nb;
    logic [7:0] d;
    logic busy, flow, done, perr, tout;
    logic [7:0] data;
    logic [2:0] o;
    int num_errors = 0;
    int n_tests = 0;
    asr_row_t rows [2] = '{
        '{16'h0000, 4'h4, 8'h0A, 4'h4, 1'b0},
        '{16'h6000, 4'h4, 8'h05, 4'h3, 1'b1}};
    asr_rx u_asr_rx (.CLK_IN(clk), .RST_N_IN(rst_n), .RXD_IN(txd), .START_IN(start),
        .FORMAT_IN(fmt), .WIDTH_IN(w), .TIMEOUT_IN(tmo), .TIMEOUT_EN_IN(ten),
        .BUSY_OUT(busy), .FLOW_OUT(flow), .DONE_OUT(done), .PERR_OUT(perr),
        .TOUT_OUT(tout), .DATA_OUT(data));
    asr_tx_model u_asr_tx_model (.clk_in(clk), .send_in(send), .data_in(d),
        .nbits_in(nb), .par_in(par), .bad_par_in(bad), .inv_in(inv),
        .period_in(PERIOD), .txd_out(txd));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (num_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic begin_rx(input logic [15:0] f, input logic [3:0] wd, input logic te);
        @(posedge clk);
        inv <= f[14];
        // Far end settles to its new idle level before the format is taken
        repeat (8) @(posedge clk);
        fmt <= f;
        w <= wd;
        ten <= te;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        #1;
        check("busy", busy, 8'h01);
        check("flow go", flow, f[14]);
        // Idle wait must not end on its own without a timeout
        if (!te)
        begin
            repeat (200) @(posedge clk);
            #1;
            check("busy idle", busy, 8'h01);
        end
    endtask
    task automatic send_frame(input logic [7:0] dv, input logic [3:0] n, input logic p, input logic b);
        @(posedge clk);
        d <= dv;
        nb <= n;
        par <= p;
        bad <= b;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
    endtask
    task automatic wait_out();
        o = '0;
        for (int i = 0; i < 40000 && o == 3'b000; i++)
        begin
            @(posedge clk);
            #1;
            o = {done, perr, tout};
        end
        check("busy end", busy, 8'h00);
        check("flow stop", flow, {7'h00, ~fmt[14]});
        // Far end still sends the rest of its stop bit
        repeat (2600) @(posedge clk);
    endtask
    initial
    begin
        {start, ten, send, par, bad, inv} = '0;
        {fmt, tmo, w, nb, d} = '0;
        rst_n = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check("reset busy", busy, 8'h00);
        check("reset flow", flow, 8'h01);
        check("reset data", data, 8'h00);
        foreach (rows[i])
        begin
            begin_rx(rows[i].fmt, rows[i].w, 1'b0);
            send_frame(rows[i].d, rows[i].nb, rows[i].par, 1'b0);
            wait_out();
            check("outcome", o, 3'b100);
            check("data", data, rows[i].d);
        end
        // Wrong parity aborts and leaves the last data in place
        begin_rx(16'h2000, 4'h4, 1'b0);
        send_frame(8'h06, 4'h3, 1'b1, 1'b1);
        wait_out();
        check("perr outcome", o, 3'b010);
        check("perr data", data, 8'h05);
        // Zero-length timeout with the line idle
        tmo <= 16'h0000;
        begin_rx(16'h0000, 4'h8, 1'b1);
        wait_out();
        check("tout outcome", o, 3'b001);
        wrap_up();
    end
    initial
    begin
        repeat (98000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
endmodule
